/* File: rtl/pllc_axil.sv */
// pllc_axil: axi4-lite slave front end giving write pulses and read lookups
`timescale 1ns/1ns
module pllc_axil
   import pllc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // axi4-lite slave
   input  wire logic [11:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [11:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // register side
   output logic             wr_en_o,
   output logic [11:0]      wr_addr_o,
   output logic [31:0]      wr_data_o,
   output logic [3:0]       wr_strb_o,
   output logic [11:0]      rd_addr_o,
   input  wire logic [31:0] rd_data_i
);
   typedef struct packed {
      logic        aw_held;
      logic [11:0] awaddr;
      logic        w_held;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic        rvalid;
      logic [31:0] rdata;
   } pllc_ax_st_t;

   localparam pllc_ax_st_t AX_RST = '0;

   pllc_ax_st_t st;
   pllc_ax_st_t n;

   // channel handshakes: one write and one read outstanding
   assign s_axi_awready_o = !st.aw_held && !st.bvalid;
   assign s_axi_wready_o  = !st.w_held && !st.bvalid;
   assign s_axi_arready_o = !st.rvalid;
   assign wr_en_o         = st.aw_held && st.w_held;
   assign wr_addr_o       = {st.awaddr[11:2], 2'h0};
   assign wr_data_o       = st.wdata;
   assign wr_strb_o       = st.wstrb;
   assign rd_addr_o       = {s_axi_araddr_i[11:2], 2'h0};

   // capture address and data in either order, answer after both
   always_comb begin
      n = st;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         n.aw_held = 1'b1;
         n.awaddr  = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         n.w_held = 1'b1;
         n.wdata  = s_axi_wdata_i;
         n.wstrb  = s_axi_wstrb_i;
      end
      if (wr_en_o) begin
         n.aw_held = 1'b0;
         n.w_held  = 1'b0;
         n.bvalid  = 1'b1;
      end else if (st.bvalid && s_axi_bready_i) begin
         n.bvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         n.rvalid = 1'b1;
         n.rdata  = rd_data_i;
      end else if (st.rvalid && s_axi_rready_i) begin
         n.rvalid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         st <= AX_RST;
      end else begin
         st <= n;
      end
   end

   assign s_axi_bvalid_o = st.bvalid;
   assign s_axi_bresp_o  = AXI_OKAY;
   assign s_axi_rvalid_o = st.rvalid;
   assign s_axi_rdata_o  = st.rdata;
   assign s_axi_rresp_o  = AXI_OKAY;
endmodule

/* File: rtl/pllc_pkg.sv */
// pllc_pkg: register map, field layout, reset values and helpers for pllc
package pllc_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_RIS    = 12'h050;
   localparam logic [11:0] OFF_IMC    = 12'h054;
   localparam logic [11:0] OFF_RCC    = 12'h060;
   localparam logic [11:0] OFF_PLL_TRANSLATION_REG = 12'h064;
   localparam logic [11:0] OFF_RUN_CLOCK_CONFIG_EXT   = 12'h070;
   localparam logic [11:0] OFF_RGATE  = 12'h100;
   localparam logic [11:0] OFF_SGATE  = 12'h110;
   localparam logic [11:0] OFF_DGATE  = 12'h120;
   localparam logic [11:0] OFF_DSLP   = 12'h144;
   // reset values
   localparam logic [31:0] RCC_RST    = 32'h0780_3AD1;
   localparam logic [31:0] RUN_CLOCK_CONFIG_EXT_RST   = 32'h0780_2810;
   localparam logic [31:0] DSLP_RST   = 32'h0780_0000;
   localparam logic [31:0] GATE_RST   = 32'h0000_0040;
   localparam logic [31:0] ZERO_W     = 32'h0000_0000;
   // run_clock_config fields
   localparam int RCC_OSC_LSB   = 4;
   localparam int RCC_OSC_W     = 2;
   localparam int RCC_CRYSTAL_SELECT_LSB  = 6;
   localparam int CRYSTAL_SELECT_W        = 5;
   localparam int RCC_BYP_BIT   = 11;
   localparam int RCC_PDN_BIT   = 13;
   localparam int RCC_USED_BIT  = 22;
   localparam int RCC_DIV_LSB   = 23;
   localparam int RCC_DIV_W     = 4;
   localparam int RCC_ACG_BIT   = 27;
   // run_clock_config_ext fields
   localparam int RUN_CLOCK_CONFIG_EXT_OSC_LSB  = 4;
   localparam int OSC_W         = 3;
   localparam int RUN_CLOCK_CONFIG_EXT_BYP_BIT  = 11;
   localparam int RUN_CLOCK_CONFIG_EXT_PDN_BIT  = 13;
   localparam int RUN_CLOCK_CONFIG_EXT_DIV_LSB  = 23;
   localparam int DIV_W         = 6;
   localparam int RUN_CLOCK_CONFIG_EXT_EXT_BIT  = 31;
   // deepsleep_clock_config fields
   localparam int DSLP_OSC_LSB  = 4;
   localparam int DSLP_DIV_LSB  = 23;
   // raw_event_status / mask bit for pll lock
   localparam int LOCK_BIT      = 6;
   // misc encodings
   localparam logic [2:0]  OSC_MAIN    = 3'h0;
   localparam logic [12:0] RELOCK_LOAD = 13'h1200;
   localparam logic [12:0] CNT_ZERO    = 13'h0000;
   localparam logic [12:0] CNT_ONE     = 13'h0001;
   localparam logic [1:0]  AXI_OKAY    = 2'h0;
   localparam logic [7:0]  DIV_ONE     = 8'h01;

   typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP, PM_RESTORE} pllc_pmode_t;

   // divisor applied is encoding plus one
   function automatic logic [7:0] pllc_divisor(input logic [5:0] enc);
      pllc_divisor = {2'h0, enc} + DIV_ONE;
   endfunction

   // byte-lane merge of a write into an old register value
   function automatic logic [31:0] pllc_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      pllc_merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            pllc_merge[b*8 +: 8] = data[b*8 +: 8];
         end
      end
   endfunction

   // crystal code to {multiplier[14:5], reference divider[4:0]}, vco ~400
   function automatic logic [31:0] pllc_xlate(input logic [4:0] crystal_select);
      case (crystal_select)
         5'h04:   pllc_xlate = {17'h0, 10'd447, 5'd4};
         5'h05:   pllc_xlate = {17'h0, 10'd217, 5'd2};
         5'h06:   pllc_xlate = {17'h0, 10'd100, 5'd1};
         5'h07:   pllc_xlate = {17'h0, 10'd293, 5'd3};
         5'h08:   pllc_xlate = {17'h0, 10'd407, 5'd5};
         5'h09:   pllc_xlate = {17'h0, 10'd80,  5'd1};
         5'h0A:   pllc_xlate = {17'h0, 10'd625, 5'd8};
         5'h0B:   pllc_xlate = {17'h0, 10'd200, 5'd3};
         5'h0C:   pllc_xlate = {17'h0, 10'd651, 5'd10};
         5'h0D:   pllc_xlate = {17'h0, 10'd217, 5'd4};
         5'h0E:   pllc_xlate = {17'h0, 10'd50,  5'd1};
         5'h0F:   pllc_xlate = {17'h0, 10'd293, 5'd6};
         default: pllc_xlate = ZERO_W;
      endcase
   endfunction
endpackage

/* File: rtl/pllc_relock.sv */
// pllc_relock: relock down counter stepped by the main oscillator
`timescale 1ns/1ns
module pllc_relock
   import pllc_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   // main oscillator pin
   input  wire logic mosc_clk_i,
   // control
   input  wire logic load_i,
   output logic      done_o
);
   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        prev;
      logic        busy;
      logic        done;
      logic [12:0] cnt;
   } pllc_rl_st_t;

   localparam pllc_rl_st_t RL_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, CNT_ZERO};

   pllc_rl_st_t st;
   pllc_rl_st_t n;

   // sync the oscillator, count its rising edges down to zero
   always_comb begin
      n      = st;
      n.s1   = mosc_clk_i;
      n.s2   = st.s1;
      n.prev = st.s2;
      n.done = 1'b0;
      if (load_i) begin
         n.cnt  = RELOCK_LOAD;
         n.busy = 1'b1;
      end else if (st.busy && st.s2 && !st.prev) begin
         n.cnt = st.cnt - CNT_ONE;
         if (st.cnt == CNT_ONE) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         st <= RL_RST;
      end else begin
         st <= n;
      end
   end

   assign done_o = st.done;

   AST_RELOAD_VALUE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      load_i |=> (st.cnt == RELOCK_LOAD) && st.busy)
      else $error("relock counter not loaded with start value");
   AST_DONE_AT_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      done_o |-> (st.cnt == CNT_ZERO) && !st.busy && $past(st.busy))
      else $error("relock done without counter at zero");
endmodule

/* File: rtl/pllc_top.sv */
// pllc_top: pll relock control, system clock selection and clock gating
`timescale 1ns/1ns
// Contract
// - pll held powered down after reset
// - pll output halved before system divider
// - crystal translated to pll settings, readable
// - crystal change recomputes internal pll settings
// - pll has normal and power-down modes
// - pll unusable until relock wait ends
// - crystal change or power-up starts relock
// - relock counter on oscillator, loads 0x1200
// - pll not selectable before relock expiry
// - stay on oscillator until lock, then switch
// - raw lock flag plus maskable lock interrupt
// - run mode clocks run-gated peripherals
// - sleep stops processor clock
// - sleep gating uses sleep or run registers
// - deep sleep gating uses deep or run
// - deep sleep source main or internal oscillator
// - deep sleep powers pll down, overrides divider; override applied only if pll was on at entry
// - wake restores clock before re-enabling peripherals
// - wfi enters sleep, deep enable, interrupt wakes
// - extended select takes fields from extended register
// - power-up enables pll, crystal loads config
// - divisor equals divider encoding plus one
// - extended register fields take precedence
module pllc_top
   import pllc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // axi4-lite slave
   input  wire logic [11:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [11:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // main oscillator pin
   input  wire logic        mosc_clk_i,
   // processor power requests
   input  wire logic        wait_for_interrupt_instr_i,
   input  wire logic        deepsleep_en_i,
   input  wire logic        wake_i,
   // pll control
   output logic             pll_enable_o,
   output logic [31:0]      pll_cfg_o,
   output logic             pll_lock_irq_o,
   // system clock control
   output logic             sysclk_use_pll_o,
   output logic [2:0]       sysclk_osc_sel_o,
   output logic [7:0]       sysclk_div_o,
   output logic             cpu_clk_en_o,
   output logic [31:0]      periph_clk_en_o,
   output logic             mosc_pwr_dn_o,
   output logic             int_osc_en_o
);
   typedef struct packed {
      logic [31:0] run_clock_config;
      logic [31:0] run_clock_config_ext;
      logic [31:0] dslp;
      logic [31:0] imc;
      logic [31:0] rgate;
      logic [31:0] sgate;
      logic [31:0] dgate;
      logic [31:0] pll_cfg;
      logic        lock;
      logic        pll_on;
      logic        dsl_pll_off;
      pllc_pmode_t pm;
      logic        o_use_pll;
      logic [2:0]  o_osc;
      logic [7:0]  o_div;
      logic        o_cpu_en;
      logic [31:0] o_periph;
      logic        o_mosc_pd;
      logic        o_int_osc;
   } pllc_main_st_t;

   localparam pllc_main_st_t MAIN_RST = '{
      RCC_RST, RUN_CLOCK_CONFIG_EXT_RST, DSLP_RST, ZERO_W, GATE_RST, GATE_RST, GATE_RST,
      ZERO_W, 1'b0, 1'b0, 1'b0, PM_RUN, 1'b0, OSC_MAIN, DIV_ONE, 1'b1,
      GATE_RST, 1'b0, 1'b0};

   pllc_main_st_t st;
   pllc_main_st_t n;

   logic        wr_en;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic [11:0] rd_addr;
   logic [31:0] rd_data;
   logic        relock_load;
   logic        relock_done;
   logic [31:0] wval;
   logic        crystal_select_chg;
   logic        ext;
   logic        byp;
   logic        pdn;
   logic        usediv;
   logic        acg;
   logic [2:0]  osc_eff;
   logic [5:0]  div_eff;
   logic [2:0]  dsl_osc;
   logic [5:0]  dsl_div;
   logic        deep;

   // bus front end
   pllc_axil u_axil (
      .sys_clk_i       (sys_clk_i),
      .rst_b_i         (rst_b_i),
      .s_axi_awaddr_i  (s_axi_awaddr_i),
      .s_axi_awvalid_i (s_axi_awvalid_i),
      .s_axi_awready_o (s_axi_awready_o),
      .s_axi_wdata_i   (s_axi_wdata_i),
      .s_axi_wstrb_i   (s_axi_wstrb_i),
      .s_axi_wvalid_i  (s_axi_wvalid_i),
      .s_axi_wready_o  (s_axi_wready_o),
      .s_axi_bresp_o   (s_axi_bresp_o),
      .s_axi_bvalid_o  (s_axi_bvalid_o),
      .s_axi_bready_i  (s_axi_bready_i),
      .s_axi_araddr_i  (s_axi_araddr_i),
      .s_axi_arvalid_i (s_axi_arvalid_i),
      .s_axi_arready_o (s_axi_arready_o),
      .s_axi_rdata_o   (s_axi_rdata_o),
      .s_axi_rresp_o   (s_axi_rresp_o),
      .s_axi_rvalid_o  (s_axi_rvalid_o),
      .s_axi_rready_i  (s_axi_rready_i),
      .wr_en_o         (wr_en),
      .wr_addr_o       (wr_addr),
      .wr_data_o       (wr_data),
      .wr_strb_o       (wr_strb),
      .rd_addr_o       (rd_addr),
      .rd_data_i       (rd_data)
   );

   // relock wait timer on the main oscillator
   pllc_relock u_relock (
      .sys_clk_i  (sys_clk_i),
      .rst_b_i    (rst_b_i),
      .mosc_clk_i (mosc_clk_i),
      .load_i     (relock_load),
      .done_o     (relock_done)
   );

   // register read mux, unmapped reads return zero
   always_comb begin
      rd_data = ZERO_W;
      case (rd_addr)
         OFF_RIS:    rd_data[LOCK_BIT] = st.lock;
         OFF_IMC:    rd_data = st.imc;
         OFF_RCC:    rd_data = st.run_clock_config;
         OFF_PLL_TRANSLATION_REG: rd_data = st.pll_cfg;
         OFF_RUN_CLOCK_CONFIG_EXT:   rd_data = st.run_clock_config_ext;
         OFF_RGATE:  rd_data = st.rgate;
         OFF_SGATE:  rd_data = st.sgate;
         OFF_DGATE:  rd_data = st.dgate;
         OFF_DSLP:   rd_data = st.dslp;
         default:    rd_data = ZERO_W;
      endcase
   end

   // next state: writes, effective fields, power mode, pll, outputs
   always_comb begin
      n        = st;
      crystal_select_chg = 1'b0;
      wval     = ZERO_W;
      if (wr_en) begin
         case (wr_addr)
            OFF_IMC:   n.imc = pllc_merge(st.imc, wr_data, wr_strb);
            OFF_RCC: begin
               wval  = pllc_merge(st.run_clock_config, wr_data, wr_strb);
               // same crystal value written again starts no relock
               crystal_select_chg = wval[RCC_CRYSTAL_SELECT_LSB +: CRYSTAL_SELECT_W]
                          != st.run_clock_config[RCC_CRYSTAL_SELECT_LSB +: CRYSTAL_SELECT_W];
               n.run_clock_config = wval;
            end
            OFF_RUN_CLOCK_CONFIG_EXT:  n.run_clock_config_ext = pllc_merge(st.run_clock_config_ext, wr_data, wr_strb);
            OFF_RGATE: n.rgate = pllc_merge(st.rgate, wr_data, wr_strb);
            OFF_SGATE: n.sgate = pllc_merge(st.sgate, wr_data, wr_strb);
            OFF_DGATE: n.dgate = pllc_merge(st.dgate, wr_data, wr_strb);
            OFF_DSLP:  n.dslp = pllc_merge(st.dslp, wr_data, wr_strb);
            default:   n.imc = st.imc;
         endcase
      end
      // crystal code translated into internal pll settings
      n.pll_cfg = pllc_xlate(n.run_clock_config[RCC_CRYSTAL_SELECT_LSB +: CRYSTAL_SELECT_W]);

      // extended register overrides base fields when selected
      ext = n.run_clock_config_ext[RUN_CLOCK_CONFIG_EXT_EXT_BIT];
      if (ext) begin
         byp     = n.run_clock_config_ext[RUN_CLOCK_CONFIG_EXT_BYP_BIT];
         pdn     = n.run_clock_config_ext[RUN_CLOCK_CONFIG_EXT_PDN_BIT];
         osc_eff = n.run_clock_config_ext[RUN_CLOCK_CONFIG_EXT_OSC_LSB +: OSC_W];
         div_eff = n.run_clock_config_ext[RUN_CLOCK_CONFIG_EXT_DIV_LSB +: DIV_W];
         dsl_div = n.dslp[DSLP_DIV_LSB +: DIV_W];
      end else begin
         byp     = n.run_clock_config[RCC_BYP_BIT];
         pdn     = n.run_clock_config[RCC_PDN_BIT];
         osc_eff = {1'b0, n.run_clock_config[RCC_OSC_LSB +: RCC_OSC_W]};
         div_eff = {2'h0, n.run_clock_config[RCC_DIV_LSB +: RCC_DIV_W]};
         dsl_div = {2'h0, n.dslp[DSLP_DIV_LSB +: RCC_DIV_W]};
      end
      usediv  = n.run_clock_config[RCC_USED_BIT];
      acg     = n.run_clock_config[RCC_ACG_BIT];
      dsl_osc = n.dslp[DSLP_OSC_LSB +: OSC_W];

      // power mode sequencing
      case (st.pm)
         PM_RUN: begin
            if (wait_for_interrupt_instr_i) begin
               if (deepsleep_en_i) begin
                  n.pm          = PM_DEEP;
                  n.dsl_pll_off = st.pll_on;
               end else begin
                  n.pm = PM_SLEEP;
               end
            end
         end
         PM_SLEEP: begin
            if (wake_i) begin
               n.pm = PM_RUN;
            end
         end
         PM_DEEP: begin
            if (wake_i) begin
               n.pm = PM_RESTORE;
            end
         end
         PM_RESTORE: begin
            // peripherals wait until the run clock is back
            if (byp || st.lock || !st.pll_on) begin
               n.pm          = PM_RUN;
               n.dsl_pll_off = 1'b0;
            end
         end
         default: n.pm = PM_RUN;
      endcase
      deep = (n.pm == PM_DEEP);

      // pll powered unless power-down bit or deep sleep override
      n.pll_on    = !pdn && !(deep && n.dsl_pll_off);
      relock_load = crystal_select_chg || (n.pll_on && !st.pll_on);
      // a restart wins over an expiry in the same cycle
      if (relock_load) begin
         n.lock = 1'b0;
      end else if (relock_done) begin
         n.lock = 1'b1;
      end

      // system clock source: oscillator until lock, then pll
      n.o_use_pll = !byp && n.pll_on && n.lock && !deep;
      n.o_osc     = deep ? dsl_osc : osc_eff;
      if (deep && n.dsl_pll_off) begin
         n.o_div = pllc_divisor(dsl_div);
      end else if (n.o_use_pll) begin
         // halved pll output doubles the divisor; at most 128 fits in 8 bits
         n.o_div = pllc_divisor(div_eff) << 1;
      end else if (usediv) begin
         n.o_div = pllc_divisor(div_eff);
      end else begin
         n.o_div = DIV_ONE;
      end
      n.o_mosc_pd = deep && (dsl_osc != OSC_MAIN);
      n.o_int_osc = deep && (dsl_osc != OSC_MAIN);

      // processor and peripheral gating per mode
      n.o_cpu_en = (n.pm == PM_RUN);
      case (n.pm)
         PM_RUN:   n.o_periph = n.rgate;
         PM_SLEEP: n.o_periph = acg ? n.sgate : n.rgate;
         default:  n.o_periph = acg ? n.dgate : n.rgate;
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         st <= MAIN_RST;
      end else begin
         st <= n;
      end
   end

   // outputs from state
   assign pll_enable_o     = st.pll_on;
   assign pll_cfg_o        = st.pll_cfg;
   assign pll_lock_irq_o   = st.lock && st.imc[LOCK_BIT];
   assign sysclk_use_pll_o = st.o_use_pll;
   assign sysclk_osc_sel_o = st.o_osc;
   assign sysclk_div_o     = st.o_div;
   assign cpu_clk_en_o     = st.o_cpu_en;
   assign periph_clk_en_o  = st.o_periph;
   assign mosc_pwr_dn_o    = st.o_mosc_pd;
   assign int_osc_en_o     = st.o_int_osc;

   // checks
   AST_PLL_OFF_AFTER_RESET: assert property (@(posedge sys_clk_i)
      $rose(rst_b_i) |-> !pll_enable_o [*2])
      else $error("pll enabled straight after reset");
   AST_NO_PLL_BEFORE_LOCK: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      sysclk_use_pll_o |-> st.lock && pll_enable_o)
      else $error("pll selected while not locked");
   AST_CRYSTAL_SELECT_RESTARTS_WAIT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $changed(st.run_clock_config[RCC_CRYSTAL_SELECT_LSB +: CRYSTAL_SELECT_W]) |-> !st.lock && !sysclk_use_pll_o)
      else $error("crystal change did not restart relock");
   AST_POWERUP_RESTARTS: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(pll_enable_o) |-> !st.lock [*2])
      else $error("pll power-up did not clear lock");
   AST_SLEEP_GATING: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (st.pm == PM_SLEEP) |-> !cpu_clk_en_o && (periph_clk_en_o ==
         (st.run_clock_config[RCC_ACG_BIT] ? st.sgate : st.rgate)))
      else $error("sleep gating wrong");
   AST_DEEP_PLL_OFF: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (st.pm == PM_DEEP) && st.dsl_pll_off |-> !pll_enable_o && !sysclk_use_pll_o)
      else $error("pll running in deep sleep");
   AST_RESTORE_BEFORE_CPU: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (st.pm == PM_DEEP) && wake_i |=> (st.pm == PM_RESTORE) && !cpu_clk_en_o)
      else $error("clocks re-enabled before restore");
   AST_WAKE_FROM_SLEEP: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (st.pm == PM_SLEEP) && wake_i |=> cpu_clk_en_o && (st.pm == PM_RUN))
      else $error("wake did not return to run");
   AST_PLL_DIVISOR: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      sysclk_use_pll_o && !st.run_clock_config_ext[RUN_CLOCK_CONFIG_EXT_EXT_BIT] |->
         sysclk_div_o == {3'h0, st.run_clock_config[RCC_DIV_LSB +: RCC_DIV_W], 1'b0} + 8'h02)
      else $error("pll divisor not twice encoding plus one");
endmodule

/* File: sim/testbench.sv */
// testbench: self-checking bench for pllc_top
`timescale 1ns/1ns
`define CHK(g,e) begin n_checks++; if ((g)!==(e)) begin n_fail++; \
$display("ERROR %0t %h %h", $time, g, e); end end
module testbench;
   import pllc_pkg::*;
   logic        sys_clk_i = 0, rst_b_i = 0, mosc_clk_i = 0, wake_i = 0;
   logic        wait_for_interrupt_instr_i = 0, deepsleep_en_i = 0;
   logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
   logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
   logic [11:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
   logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, periph_clk_en_o, pll_cfg_o;
   logic [3:0]  s_axi_wstrb_i = 4'hF;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic        s_axi_arready_o, s_axi_rvalid_o, pll_enable_o, pll_lock_irq_o;
   logic        sysclk_use_pll_o, cpu_clk_en_o, mosc_pwr_dn_o, int_osc_en_o;
   logic [2:0]  sysclk_osc_sel_o;
   logic [7:0]  sysclk_div_o;
   int          n_fail = 0, n_checks = 0, seed = 32'h10303E70;
   logic [31:0] mdl [int];
   logic [31:0] d, v, rg, sg, dg;
   // system clock, free-running oscillator and hang guard
   initial forever #10 sys_clk_i = ~sys_clk_i;
   initial begin #7; forever #50 mosc_clk_i = ~mosc_clk_i; end
   initial begin #1800000; n_fail++; give_verdict; end
   pllc_top uut (.*);
   task automatic give_verdict;
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one axi write; the model follows only mapped writable registers
   task automatic wr(input logic [11:0] a, input logic [31:0] x);
      @(posedge sys_clk_i);
      s_axi_awaddr_i  <= a;
      s_axi_wdata_i   <= x;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i  <= 1'b1;
      s_axi_bready_i  <= 1'b1;
      if (mdl.exists(a)) mdl[a] = x;
      forever begin @(posedge sys_clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o) begin s_axi_bready_i <= 1'b0; break; end
      end
      @(negedge sys_clk_i);
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge sys_clk_i);
      s_axi_araddr_i  <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i  <= 1'b1;
      forever begin @(posedge sys_clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o) begin d = s_axi_rdata_o; s_axi_rready_i <= 1'b0;
            break; end
      end
   endtask
   // read back every modelled register, an unmapped word and the translation
   task automatic cmp_regs(input logic [31:0] xl);
      foreach (mdl[a]) begin rd(a[11:0]); `CHK(d, mdl[a]) end
      rd(12'h200); `CHK(d, ZERO_W)
      rd(OFF_PLL_TRANSLATION_REG); `CHK(d, xl)
      `CHK(pll_cfg_o, xl)
   endtask
   task automatic lock_wait;
      int i;
      for (i = 0; i < 30000 && sysclk_use_pll_o !== 1'b1; i++)
         @(posedge sys_clk_i);
      repeat (3) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask
   // one-cycle wait-for-interrupt pulse with deep sleep enable set from ds
   task automatic wait_for_interrupt_instr(input logic ds);
      @(posedge sys_clk_i);
      wait_for_interrupt_instr_i <= 1'b1;
      deepsleep_en_i <= ds;
      @(posedge sys_clk_i);
      wait_for_interrupt_instr_i <= 1'b0;
      @(negedge sys_clk_i);
   endtask
   task automatic wk;
      @(posedge sys_clk_i);
      wake_i <= 1'b1;
      @(posedge sys_clk_i);
      wake_i <= 1'b0;
      @(negedge sys_clk_i);
   endtask
   // main sequence
   initial begin
      mdl[OFF_RCC] = RCC_RST; mdl[OFF_RUN_CLOCK_CONFIG_EXT] = RUN_CLOCK_CONFIG_EXT_RST; mdl[OFF_DSLP] = DSLP_RST;
      mdl[OFF_IMC] = ZERO_W; mdl[OFF_RGATE] = GATE_RST;
      mdl[OFF_SGATE] = GATE_RST; mdl[OFF_DGATE] = GATE_RST;
      repeat (12) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      @(negedge sys_clk_i);
      `CHK({pll_enable_o, sysclk_use_pll_o, sysclk_div_o}, 10'h001)
      cmp_regs(32'h0000_1903);
      rg = $random(seed); sg = $random(seed); dg = $random(seed);
      wr(OFF_RGATE, rg); wr(OFF_SGATE, sg); wr(OFF_DGATE, dg);
      wr(OFF_PLL_TRANSLATION_REG, rg); wr(12'h200, rg); wr(OFF_IMC, 32'h0000_0040);
      // crystal, power-up, divider and pll select in one write
      v = RCC_RST; v[10:6] = 5'h0E; v[13] = 1'b0; v[11] = 1'b0;
      v[22] = 1'b1; v[26:23] = 4'h3; v[27] = 1'b1;
      wr(OFF_RCC, v);
      `CHK({pll_enable_o, sysclk_use_pll_o, pll_lock_irq_o}, 3'b100)
      cmp_regs(32'h0000_0641);
      rd(OFF_RIS); `CHK(d, ZERO_W)
      lock_wait;
      `CHK({sysclk_use_pll_o, sysclk_div_o, pll_lock_irq_o, periph_clk_en_o},
           {1'b1, 8'h08, 1'b1, rg})
      wr(OFF_RCC, v); rd(OFF_RIS); `CHK(d, 32'h0000_0040)
      wait_for_interrupt_instr(1'b0);
      `CHK({cpu_clk_en_o, sysclk_use_pll_o, periph_clk_en_o}, {2'b01, sg})
      wk; `CHK({cpu_clk_en_o, periph_clk_en_o}, {1'b1, rg})
      wait_for_interrupt_instr(1'b1);
      `CHK({cpu_clk_en_o, pll_enable_o, sysclk_use_pll_o, sysclk_div_o,
            periph_clk_en_o}, {3'b000, 8'h10, dg})
      `CHK({mosc_pwr_dn_o, int_osc_en_o, sysclk_osc_sel_o}, 5'h00)
      wk; `CHK({cpu_clk_en_o, pll_enable_o}, 2'b01)
      lock_wait;
      `CHK({cpu_clk_en_o, sysclk_use_pll_o, sysclk_div_o, periph_clk_en_o},
           {2'b11, 8'h08, rg})
      // extended register powered down and bypassed, largest divider
      v = RUN_CLOCK_CONFIG_EXT_RST; v[31] = 1'b1; v[28:23] = 6'h3F;
      wr(OFF_RUN_CLOCK_CONFIG_EXT, v);
      `CHK({pll_enable_o, sysclk_use_pll_o, sysclk_div_o}, 10'h040)
      give_verdict;
   end
endmodule
